// [hw/ballast_seq.sv]
// Start-up phase sequencer of the fluorescent lamp ballast controller
`timescale 1ns/1ps
`default_nettype none
module ballast_seq #(
  parameter logic [ballast_seq_pkg::TIMER_W-1:0] T_BUS95 =
    ballast_seq_pkg::TIMER_W'(ballast_seq_pkg::BUS95_CYC),
  parameter logic [ballast_seq_pkg::TIMER_W-1:0] T_SOFT_STEP =
    ballast_seq_pkg::TIMER_W'(ballast_seq_pkg::SOFT_STEP_CYC),
  parameter logic [ballast_seq_pkg::TIMER_W-1:0] T_PREHEAT_STEP =
    ballast_seq_pkg::TIMER_W'(ballast_seq_pkg::PREHEAT_STEP_CYC),
  parameter logic [ballast_seq_pkg::TIMER_W-1:0] T_IGN_MAX =
    ballast_seq_pkg::TIMER_W'(ballast_seq_pkg::IGN_MAX_CYC),
  parameter logic [ballast_seq_pkg::TIMER_W-1:0] T_PRERUN =
    ballast_seq_pkg::TIMER_W'(ballast_seq_pkg::PRERUN_CYC)
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Comparator flags from the power stage
  input wire logic [ballast_seq_pkg::FLAG_W-1:0] i_flags,
  // Frequency and preheat configuration words
  input wire ballast_seq_pkg::freq_cfg_type i_cfg,
  // Sequencer outputs
  output ballast_seq_pkg::phase_type o_phase,
  output logic [ballast_seq_pkg::FREQ_W-1:0] o_freq_set,
  output ballast_seq_pkg::drive_type o_drive
);
  import ballast_seq_pkg::*;

  state_type st;
  state_type next_st;
  logic [FLAG_W-1:0] f;
  logic fil_ok;
  logic bus_ok;
  logic [FREQ_W-1:0] delta_soft;
  logic [FREQ_W-1:0] delta_ign;
  logic [STEP_W-1:0] step_inc;

  localparam logic [TIMER_W-1:0] T_SENSE = TIMER_W'(SENSE_CYC);
  localparam logic [PFC_W-1:0] T_PFC = PFC_W'(PFC_CYC);
  localparam logic [TIMER_W-1:0] T_IGN_STEP = TIMER_W'(IGN_STEP_CYC);
  localparam logic [STEP_W-1:0] SOFT_LAST = STEP_W'(SOFT_STEPS);
  localparam logic [STEP_W-1:0] IGN_LAST = STEP_W'(IGN_STEPS);

  assign f = st.sync2;
  // Low side open above restart threshold, high side open with no sink
  assign fil_ok = !f[F_RES_HIGH] && (f[F_LVS_A] || f[F_LVS_B]);
  assign bus_ok = f[F_BUS_MIN] && !f[F_BUS_MAX];
  assign step_inc = st.step + 1'b1;
  assign delta_soft = (i_cfg.start > i_cfg.preheat) ?
    FREQ_W'((i_cfg.start - i_cfg.preheat) / SOFT_STEPS) : '0;
  assign delta_ign = (i_cfg.preheat > i_cfg.run) ?
    FREQ_W'((i_cfg.preheat - i_cfg.run) / IGN_STEPS) : '0;

  always_comb begin
    next_st = st;
    next_st.sync1 = i_flags;
    next_st.sync2 = st.sync1;
    next_st.timer = st.timer + 1'b1;
    next_st.phase_timer = st.phase_timer + 1'b1;
    // Power factor stage follows the inverter after a fixed delay
    if (st.inv_en && !st.pfc_en) begin
      if (st.pfc_cnt == T_PFC - 1'b1) begin
        next_st.pfc_en = 1'b1;
      end else begin
        next_st.pfc_cnt = st.pfc_cnt + 1'b1;
      end
    end
    if (st.fault) begin
      // Gates stay off until a lamp removal or a supply lockout clears the fault
      next_st.inv_en = 1'b0;
      next_st.pfc_en = 1'b0;
      next_st.pfc_cnt = '0;
      if (f[F_REMOVED]) begin
        next_st.fault = 1'b0;
        next_st.phase = PH_HYST;
        next_st.timer = '0;
        next_st.blocked = 1'b0;
      end
    end else begin
      unique case (st.phase)
        PH_LOCKOUT: begin
          next_st.timer = '0;
          if (f[F_LOCKOUT]) begin
            next_st.phase = PH_HYST;
          end
        end
        PH_HYST: begin
          // Sensing delay restarts while filaments or supply are not ready
          if (!f[F_START] || !fil_ok || st.blocked) begin
            next_st.timer = '0;
          end else if (st.timer == T_SENSE - 1'b1) begin
            if (bus_ok) begin
              next_st.phase = PH_BUS;
              next_st.inv_en = 1'b1;
              next_st.freq = i_cfg.start;
              next_st.timer = '0;
              next_st.phase_timer = '0;
            end else begin
              next_st.blocked = 1'b1;
            end
          end
        end
        PH_BUS: begin
          if (f[F_BUS_95]) begin
            next_st.phase = PH_SOFT;
            next_st.timer = '0;
            next_st.step = '0;
          end else if (st.phase_timer == T_BUS95 - 1'b1) begin
            next_st.fault = 1'b1;
            next_st.inv_en = 1'b0;
            next_st.pfc_en = 1'b0;
          end
        end
        PH_SOFT: begin
          if (st.timer == T_SOFT_STEP - 1'b1) begin
            next_st.timer = '0;
            next_st.step = step_inc;
            if (step_inc == SOFT_LAST) begin
              next_st.freq = i_cfg.preheat;
              next_st.phase = PH_PREHEAT;
              next_st.step = '0;
            end else begin
              next_st.freq = i_cfg.start -
                FREQ_W'(delta_soft * step_inc);
            end
          end
        end
        PH_PREHEAT: begin
          if (st.step == i_cfg.preheat_time) begin
            next_st.phase = PH_IGN;
            next_st.timer = '0;
            next_st.phase_timer = '0;
            next_st.step = '0;
            next_st.frozen = 1'b0;
          end else if (st.timer == T_PREHEAT_STEP - 1'b1) begin
            next_st.timer = '0;
            next_st.step = step_inc;
          end
        end
        PH_IGN: begin
          if (f[F_IGNITED]) begin
            next_st.phase = PH_PRERUN;
            next_st.timer = '0;
          end else if (st.phase_timer == T_IGN_MAX - 1'b1) begin
            next_st.fault = 1'b1;
            next_st.inv_en = 1'b0;
            next_st.pfc_en = 1'b0;
          end else if (f[F_IGN_SENSE] || st.frozen) begin
            next_st.frozen = 1'b1;
          end else if (st.step != IGN_LAST &&
                       st.timer == T_IGN_STEP - 1'b1) begin
            next_st.timer = '0;
            next_st.step = step_inc;
            if (step_inc == IGN_LAST) begin
              next_st.freq = i_cfg.run;
            end else begin
              next_st.freq = i_cfg.preheat -
                FREQ_W'(delta_ign * step_inc);
            end
          end
        end
        PH_PRERUN: begin
          if (st.timer == T_PRERUN - 1'b1) begin
            next_st.phase = PH_RUN;
          end
        end
        PH_RUN: begin
          next_st.timer = '0;
        end
      endcase
    end
    // Supply below lockout wins over everything else
    if (!f[F_LOCKOUT]) begin
      next_st = ST_RESET;
      next_st.sync1 = i_flags;
      next_st.sync2 = st.sync1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st <= ST_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign o_phase = st.phase;
  assign o_freq_set = st.freq;
  always_comb begin
    o_drive.inverter_en = st.inv_en;
    o_drive.power_factor_stage_en = st.pfc_en;
    o_drive.ignition_ctrl_en = (st.phase == PH_IGN) && !st.fault;
    o_drive.fault_monitor_en = (st.phase == PH_RUN) && !st.fault;
    o_drive.restart_source_high = !(f[F_LVS_A] || f[F_LVS_B]);
    o_drive.low_filament_open = f[F_RES_HIGH];
    o_drive.high_filament_open = !(f[F_LVS_A] || f[F_LVS_B]);
    o_drive.fault = st.fault;
  end

  lockout_return_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    !f[F_LOCKOUT] |=> st.phase == PH_LOCKOUT && !st.inv_en && !st.pfc_en)
    else $error("lockout did not clear sequencer");

  fault_gates_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.fault |-> !o_drive.inverter_en && !o_drive.power_factor_stage_en)
    else $error("gates on during latched fault");

  power_up_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $rose(st.inv_en) |-> st.freq == $past(i_cfg.start) &&
      $past(fil_ok) && $past(bus_ok) && st.phase == PH_BUS)
    else $error("bad inverter start");

  pfc_delay_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $rose(st.pfc_en) |-> $past(st.pfc_cnt) == T_PFC - 1'b1 && st.inv_en)
    else $error("power factor stage enabled at wrong time");

  soft_step_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_SOFT && st.timer != T_SOFT_STEP - 1'b1 &&
      f[F_LOCKOUT] |=> $stable(st.freq))
    else $error("soft start setpoint changed between steps");

  soft_end_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_PREHEAT && $past(st.phase) == PH_SOFT |->
      st.freq == $past(i_cfg.preheat) && $past(st.step) == SOFT_LAST - 1'b1)
    else $error("soft start ended off the preheat setpoint");

  ign_freeze_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_IGN && st.frozen && f[F_LOCKOUT] |=> $stable(st.freq))
    else $error("ignition sweep not frozen");

  ign_timeout_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_IGN && !st.fault && f[F_LOCKOUT] && !f[F_IGNITED] &&
      st.phase_timer == T_IGN_MAX - 1'b1 |=> st.fault && !st.inv_en)
    else $error("ignition timeout missed");

  prerun_len_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_RUN && $past(st.phase) == PH_PRERUN |->
      $past(st.timer) == T_PRERUN - 1'b1)
    else $error("pre-run length wrong");

  bus_block_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.blocked && f[F_LOCKOUT] |=> st.blocked && !st.inv_en)
    else $error("blocked start released early");

  filament_hold_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_HYST && !fil_ok |=> st.phase != PH_BUS)
    else $error("power up with defective filament");

  hyst_entry_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_LOCKOUT && f[F_LOCKOUT] |=> st.phase == PH_HYST)
    else $error("supply flag did not start filament checks");

  sense_delay_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $rose(st.inv_en) |->
      $past(st.timer) == T_SENSE - 1'b1 && $past(st.phase) == PH_HYST)
    else $error("power up before the sensing delay");

  bus_sample_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_HYST && f[F_LOCKOUT] && f[F_START] && fil_ok &&
      !st.blocked && !bus_ok && st.timer == T_SENSE - 1'b1 |=>
      st.blocked && !st.inv_en)
    else $error("start not blocked with bus out of corridor");

  soft_entry_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_BUS && !st.fault && f[F_LOCKOUT] && f[F_BUS_95] |=>
      st.phase == PH_SOFT)
    else $error("bus level did not start soft start");

  soft_drop_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_SOFT && $past(st.phase) == PH_SOFT &&
      $changed(st.freq) |-> st.freq == $past(st.freq) - $past(delta_soft))
    else $error("soft start step size wrong");

  soft_pace_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_SOFT && $changed(st.freq) |->
      $past(st.timer) == T_SOFT_STEP - 1'b1)
    else $error("soft start setpoint moved off a step boundary");

  preheat_hold_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_PREHEAT && f[F_LOCKOUT] |=> $stable(st.freq))
    else $error("setpoint moved during preheat");

  preheat_step_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_PREHEAT && $past(st.phase) == PH_PREHEAT &&
      $changed(st.step) |-> $past(st.timer) == T_PREHEAT_STEP - 1'b1 &&
      st.step == $past(st.step) + 1'b1)
    else $error("preheat time quantum wrong");

  preheat_end_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_PREHEAT && f[F_LOCKOUT] &&
      st.step == i_cfg.preheat_time |=> st.phase == PH_IGN)
    else $error("preheat did not end at programmed time");

  ign_drop_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_IGN && $changed(st.freq) && st.step != IGN_LAST |->
      st.freq == $past(st.freq) - $past(delta_ign))
    else $error("ignition step size wrong");

  ign_pace_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_IGN && $changed(st.freq) |->
      $past(st.timer) == T_IGN_STEP - 1'b1)
    else $error("ignition setpoint moved off a step boundary");

  prerun_entry_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.phase == PH_IGN && !st.fault && f[F_LOCKOUT] && f[F_IGNITED] |=>
      st.phase == PH_PRERUN && st.inv_en)
    else $error("ignition did not lead to pre-run");

  fault_hold_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.fault && f[F_LOCKOUT] && !f[F_REMOVED] |=> st.fault)
    else $error("latched fault released without cause");

  fault_clear_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    st.fault && f[F_LOCKOUT] && f[F_REMOVED] |=>
      !st.fault && st.phase == PH_HYST && !st.inv_en)
    else $error("lamp removal did not clear the fault");

  phase_order_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    $changed(st.phase) && st.phase != PH_LOCKOUT && st.phase != PH_HYST |->
      ($past(st.phase) == PH_HYST && st.phase == PH_BUS) ||
      ($past(st.phase) == PH_BUS && st.phase == PH_SOFT) ||
      ($past(st.phase) == PH_SOFT && st.phase == PH_PREHEAT) ||
      ($past(st.phase) == PH_PREHEAT && st.phase == PH_IGN) ||
      ($past(st.phase) == PH_IGN && st.phase == PH_PRERUN) ||
      ($past(st.phase) == PH_PRERUN && st.phase == PH_RUN))
    else $error("phase skipped or out of order");

  lockout_clear_a: assert property (@(posedge i_clk_sys)
    disable iff (!i_rst_n)
    !f[F_LOCKOUT] |=> st.timer == '0 && st.phase_timer == '0 &&
      st.freq == '0 && !st.fault && !st.blocked)
    else $error("lockout left timers or setpoint behind");

endmodule
`default_nettype wire

// [hw/ballast_seq_pkg.sv]
// Constants, types and state layout of the lamp ballast start-up sequencer
// Notes on behaviour
// - Eight ordered phases, current phase is visible
// - Lockout flag rising enters filament-check hysteresis
// - Wait 80 us after start, check bus
// - Bus out of corridor blocks until lockout
// - Power-up enables inverter at start frequency
// - Power factor stage follows after 300 us
// - Bus above 95 percent within 80 ms
// - Soft start: 15 steps of 650 us
// - Hold preheat frequency for programmed time
// - Ignition sweep: 127 steps of 324 us
// - Ignition sense flag freezes the sweep
// - Ignition over 237 ms latches fault
// - Pre-run lasts 625 ms, then run
// - Run mode enables full fault monitoring
// - Defective filament keeps sequencer in monitoring
// - Restart sense above threshold: low filament open
// - No lamp sense sink: higher restart source
// - Preheat time quantised into 127 steps
// - Latched fault keeps gates off until cleared
package ballast_seq_pkg;

  localparam int unsigned CLK_MHZ = 10;
  localparam int FREQ_W = 16;
  localparam int TIMER_W = 26;
  localparam int STEP_W = 7;
  localparam int PFC_W = 12;

  localparam int unsigned SENSE_US = 80;
  localparam int unsigned PFC_DELAY_US = 300;
  localparam int unsigned BUS95_MS = 80;
  localparam int unsigned SOFT_STEP_US = 650;
  localparam int unsigned PREHEAT_MAX_MS = 2500;
  localparam int unsigned IGN_STEP_US = 324;
  localparam int unsigned IGN_MAX_MS = 237;
  localparam int unsigned PRERUN_MS = 625;

  localparam int unsigned SOFT_STEPS = 15;
  localparam int unsigned IGN_STEPS = 127;
  localparam int unsigned PREHEAT_STEPS = 127;

  localparam int unsigned SENSE_CYC = SENSE_US * CLK_MHZ;
  localparam int unsigned PFC_CYC = PFC_DELAY_US * CLK_MHZ;
  localparam int unsigned BUS95_CYC = BUS95_MS * CLK_MHZ * 1000;
  localparam int unsigned SOFT_STEP_CYC = SOFT_STEP_US * CLK_MHZ;
  localparam int unsigned PREHEAT_STEP_CYC =
    PREHEAT_MAX_MS * CLK_MHZ * 1000 / PREHEAT_STEPS;
  localparam int unsigned IGN_STEP_CYC = IGN_STEP_US * CLK_MHZ;
  localparam int unsigned IGN_MAX_CYC = IGN_MAX_MS * CLK_MHZ * 1000;
  localparam int unsigned PRERUN_CYC = PRERUN_MS * CLK_MHZ * 1000;

  // Flag vector bit positions
  localparam int FLAG_W = 11;
  localparam int F_LOCKOUT = 0;
  localparam int F_START = 1;
  localparam int F_BUS_MIN = 2;
  localparam int F_BUS_MAX = 3;
  localparam int F_BUS_95 = 4;
  localparam int F_RES_HIGH = 5;
  localparam int F_LVS_A = 6;
  localparam int F_LVS_B = 7;
  localparam int F_IGN_SENSE = 8;
  localparam int F_IGNITED = 9;
  localparam int F_REMOVED = 10;

  typedef enum logic [2:0] {
    PH_LOCKOUT = 3'h0,
    PH_HYST = 3'h1,
    PH_BUS = 3'h3,
    PH_SOFT = 3'h2,
    PH_PREHEAT = 3'h6,
    PH_IGN = 3'h7,
    PH_PRERUN = 3'h5,
    PH_RUN = 3'h4
  } phase_type;

  typedef struct packed {
    logic [FREQ_W-1:0] start;
    logic [FREQ_W-1:0] preheat;
    logic [FREQ_W-1:0] run;
    logic [STEP_W-1:0] preheat_time;
  } freq_cfg_type;

  typedef struct packed {
    logic inverter_en;
    logic power_factor_stage_en;
    logic ignition_ctrl_en;
    logic fault_monitor_en;
    logic restart_source_high;
    logic low_filament_open;
    logic high_filament_open;
    logic fault;
  } drive_type;

  typedef struct packed {
    logic [FLAG_W-1:0] sync1;
    logic [FLAG_W-1:0] sync2;
    phase_type phase;
    logic fault;
    logic blocked;
    logic frozen;
    logic inv_en;
    logic pfc_en;
    logic [PFC_W-1:0] pfc_cnt;
    logic [FREQ_W-1:0] freq;
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] phase_timer;
    logic [STEP_W-1:0] step;
  } state_type;

  localparam state_type ST_RESET = '0;

endpackage

// [test/ballast_power_stage.sv]
// Comparator flags of the power stage facing the start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module ballast_power_stage #(
  parameter logic [15:0] IGN_FREQ = 16'h0FF0
) (
  // Clock
  input wire logic i_clk_sys,
  // Stage conditions set by the bench
  input wire logic [1:0] i_supply,
  input wire logic i_fil_lo,
  input wire logic i_fil_hi,
  input wire logic i_fil_hi_b,
  input wire logic i_bus_ok,
  input wire logic i_lamp_good,
  input wire logic i_removed,
  // Sequencer outputs seen by the stage
  input wire logic [15:0] i_freq,
  input wire ballast_seq_pkg::drive_type i_drive,
  // Comparator flags
  output logic [ballast_seq_pkg::FLAG_W-1:0] o_flags
);
  import ballast_seq_pkg::*;
  logic [7:0] boost_cnt;
  logic [3:0] strike_cnt;
  logic sense;
  // Ignition slope seen once the sweep nears resonance
  assign sense = i_drive.inverter_en && i_freq != 16'h0 && i_freq <= IGN_FREQ;
  // Bus climbs only while the power factor stage switches
  always @(posedge i_clk_sys) begin
    boost_cnt <= !i_drive.power_factor_stage_en ? 8'h0 :
      boost_cnt + {7'h0, boost_cnt != 8'h14};
    strike_cnt <= !(sense && i_lamp_good) ? 4'h0 :
      strike_cnt + {3'h0, strike_cnt != 4'h8};
  end
  always_comb begin
    o_flags = '0;
    o_flags[F_LOCKOUT] = i_supply != 2'h0;
    o_flags[F_START] = i_supply == 2'h2;
    o_flags[F_BUS_MIN] = i_bus_ok;
    o_flags[F_BUS_MAX] = !i_bus_ok;
    o_flags[F_BUS_95] = boost_cnt == 8'h14;
    o_flags[F_RES_HIGH] = !i_fil_lo;
    o_flags[F_LVS_A] = i_fil_hi;
    o_flags[F_LVS_B] = i_fil_hi_b;
    o_flags[F_IGN_SENSE] = sense;
    o_flags[F_IGNITED] = strike_cnt == 4'h8;
    o_flags[F_REMOVED] = i_removed;
  end
endmodule
`default_nettype wire

// [test/ballast_seq_tb.sv]
// Self-checking bench of the lamp ballast start-up sequencer
`timescale 1ns/1ps
`default_nettype none
module ballast_seq_tb;
  import ballast_seq_pkg::*;
  localparam logic [15:0] F_ST = 16'h2000;
  localparam logic [15:0] F_PH = 16'h1000;
  localparam logic [15:0] F_RN = 16'h0800;
  localparam int D_SOFT = (F_ST - F_PH) / 15;
  localparam int D_IGN = (F_PH - F_RN) / 127;
  localparam int T_IGN = 20000;
  logic i_clk_sys, i_rst_n, fil_lo, fil_hi, bus_ok, lamp_good, removed;
  logic fil_hi_b;
  logic [1:0] supply;
  logic [FLAG_W-1:0] flags;
  freq_cfg_type cfg;
  phase_type o_phase;
  logic [FREQ_W-1:0] o_freq_set;
  drive_type o_drive;
  int err_total, n_tests, n;

  ballast_seq #(.T_BUS95(26'h1000), .T_SOFT_STEP(26'h8),
    .T_PREHEAT_STEP(26'hA), .T_IGN_MAX(26'h4E20), .T_PRERUN(26'h14)
  ) dut_u (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_flags(flags),
    .i_cfg(cfg), .o_phase(o_phase), .o_freq_set(o_freq_set),
    .o_drive(o_drive));

  ballast_power_stage stage_u (
    .i_clk_sys(i_clk_sys), .i_supply(supply), .i_fil_lo(fil_lo),
    .i_fil_hi(fil_hi), .i_fil_hi_b(fil_hi_b), .i_bus_ok(bus_ok),
    .i_lamp_good(lamp_good),
    .i_removed(removed), .i_freq(o_freq_set), .i_drive(o_drive),
    .o_flags(flags));

  initial begin
    i_clk_sys = 1'b0;
    forever #50 i_clk_sys = ~i_clk_sys;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %0h, expected %0h", $time, got, exp);
    end
  endtask

  // Kind 0 phase, 1 setpoint change, 2 stage enable, 3 fault
  task automatic wait_for(input int kind, input phase_type p, input int lim);
    logic [FREQ_W-1:0] f0;
    f0 = o_freq_set;
    n = 0;
    while (n < lim && !(kind == 0 ? o_phase === p : kind == 1 ?
        o_freq_set !== f0 : kind == 2 ? o_drive.power_factor_stage_en :
        o_drive.fault)) begin
      @(negedge i_clk_sys);
      n++;
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic t_reset();
    check(o_phase, PH_LOCKOUT);
    check(o_freq_set, 0);
    check(o_drive, 8'h0A);
  endtask

  task automatic t_hold();
    supply = 2'h1;
    wait_for(0, PH_HYST, 10);
    check(n < 6, 1);
    repeat (4) @(negedge i_clk_sys);
    check({o_drive.restart_source_high, o_drive.low_filament_open}, 2'h3);
    fil_hi_b = 1'b1;
    supply = 2'h2;
    repeat (1000) @(negedge i_clk_sys);
    check({o_phase, o_drive.inverter_en, o_drive.restart_source_high},
      {PH_HYST, 2'h0});
    fil_lo = 1'b1;
    repeat (1000) @(negedge i_clk_sys);
    check({o_phase, o_drive.inverter_en}, {PH_HYST, 1'b0});
    supply = 2'h0;
    wait_for(0, PH_LOCKOUT, 10);
    check({o_phase, o_freq_set, o_drive.inverter_en}, 0);
  endtask

  task automatic to_ign();
    int k;
    fil_lo = 1'b1;
    fil_hi = 1'b1;
    fil_hi_b = 1'b0;
    bus_ok = 1'b1;
    supply = 2'h1;
    repeat (5) @(negedge i_clk_sys);
    supply = 2'h2;
    wait_for(0, PH_BUS, 900);
    check(n >= SENSE_CYC && n <= SENSE_CYC + 4, 1);
    check({o_freq_set, o_drive.inverter_en, o_drive.power_factor_stage_en},
      {F_ST, 2'h2});
    wait_for(2, PH_BUS, 3100);
    check(n, PFC_CYC);
    wait_for(0, PH_SOFT, 60);
    check(o_phase, PH_SOFT);
    for (k = 1; k <= 15; k++) begin
      wait_for(1, PH_SOFT, 12);
      if (k > 1) check(n, 8);
      check(o_freq_set, k < 15 ? F_ST - k * D_SOFT : F_PH);
    end
    wait_for(0, PH_PREHEAT, 3);
    check(o_phase, PH_PREHEAT);
    wait_for(0, PH_IGN, 40);
    check(n >= 29 && n <= 31, 1);
    check(o_drive.ignition_ctrl_en, 1);
    wait_for(1, PH_IGN, 3300);
    check(n >= IGN_STEP_CYC - 1 && n <= IGN_STEP_CYC + 1, 1);
    check(o_freq_set, F_PH - D_IGN);
  endtask

  task automatic t_run();
    lamp_good = 1'b1;
    to_ign();
    wait_for(0, PH_PRERUN, 20);
    check({o_phase, o_freq_set}, {PH_PRERUN, 16'(F_PH - D_IGN)});
    wait_for(0, PH_RUN, 40);
    check(n >= 19 && n <= 21, 1);
    check({o_drive.fault_monitor_en, o_drive.ignition_ctrl_en}, 2'h2);
    supply = 2'h0;
    wait_for(0, PH_LOCKOUT, 10);
    check({o_freq_set, o_drive.inverter_en,
      o_drive.power_factor_stage_en}, 0);
  endtask

  task automatic t_fault();
    lamp_good = 1'b0;
    to_ign();
    repeat (2 * IGN_STEP_CYC) @(negedge i_clk_sys);
    check(o_freq_set, F_PH - D_IGN);
    wait_for(3, PH_IGN, T_IGN);
    n = n + 3 * IGN_STEP_CYC;
    check(n > T_IGN - 5 && n < T_IGN + 5, 1);
    repeat (50) @(negedge i_clk_sys);
    check({o_drive.fault, o_drive.inverter_en, o_drive.power_factor_stage_en,
      o_drive.ignition_ctrl_en}, 4'h8);
    removed = 1'b1;
    wait_for(0, PH_HYST, 10);
    check(o_drive.fault, 0);
    removed = 1'b0;
    supply = 2'h0;
    wait_for(0, PH_LOCKOUT, 10);
    check(o_phase, PH_LOCKOUT);
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    i_rst_n = 1'b0;
    supply = 2'h0;
    fil_lo = 1'b0;
    fil_hi = 1'b0;
    fil_hi_b = 1'b0;
    bus_ok = 1'b0;
    lamp_good = 1'b0;
    removed = 1'b0;
    cfg = '{start: F_ST, preheat: F_PH, run: F_RN, preheat_time: 7'h3};
    repeat (10) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    t_reset();
    t_hold();
    t_run();
    t_fault();
    report_and_stop();
  end

  // Whole run needs about 33000 cycles
  initial begin
    #6000000;
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
